// >>> core/ipm_consts.svh
// Offsets, field positions, write masks and reset values for the priority
// interrupt controller. Included by the package and the design modules.
`ifndef IPM_CONSTS_SVH
`define IPM_CONSTS_SVH

// Module-level register offsets (word addresses).
`define IPM_OFF_PRIO_0 5'h00
`define IPM_OFF_PRIO_9 5'h09
`define IPM_OFF_VBA 5'h0A
`define IPM_OFF_FAST_MATCH_0 5'h0B
`define IPM_OFF_FAST_VECTOR_LOW_0 5'h0C
`define IPM_OFF_FAST_VECTOR_HIGH_0 5'h0D
`define IPM_OFF_FAST_MATCH_1 5'h0E
`define IPM_OFF_FAST_VECTOR_LOW_1 5'h0F
`define IPM_OFF_FAST_VECTOR_HIGH_1 5'h10
`define IPM_OFF_PEND_0 5'h11
`define IPM_OFF_PEND_5 5'h16
`define IPM_OFF_CTRL 5'h1D

// System-level base address of the block.
`define IPM_BASE_ADDR 24'h00F1A0
`define IPM_OFF_W 5

// Implemented bits of the priority registers.
`define IPM_PRIO0_MASK 16'h3C00
`define IPM_PRIO1_MASK 16'h003F
`define IPM_PRIO2_MASK 16'hFFCF
`define IPM_PRIO_MASK 16'hFFFF

// Field widths.
`define IPM_VBA_W 13
`define IPM_VEC_W 7
`define IPM_FIVAH_W 5
`define IPM_VAB_W 21
`define IPM_NSRC 82
`define IPM_NPRIO 10

// Sources with a level fixed at 3; the first programmable field feeds this one.
`define IPM_FIXED_SRC 2
// Source numbers of the two external request pins.
`define IPM_SRC_EXT_A 7'h12
`define IPM_SRC_EXT_B 7'h13

// Control register bit positions.
`define IPM_CTRL_INT 15
`define IPM_CTRL_CURRENT_PRIORITY_FIELD_LO 13
`define IPM_CTRL_VAB_LO 6
`define IPM_CTRL_DIS 5
`define IPM_CTRL_ONE 4
`define IPM_CTRL_STB 3
`define IPM_CTRL_STA 2
`define IPM_CTRL_EDB 1
`define IPM_CTRL_EDA 0

// Reset values.
`define IPM_RST_WORD 16'h0000
`define IPM_PEND5_FILL 16'hFFFE

`endif

// >>> core/ipm_pkg.sv
// Types shared by the priority interrupt controller modules.
// Assumes ipm_consts.svh is on the include path.
`include "ipm_consts.svh"

package ipm_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ipm_bus_req_t;

  typedef struct packed {
    logic req;
    logic [1:0] level;
    logic [`IPM_VEC_W-1:0] vector;
    logic [`IPM_VAB_W-1:0] vector_address_bus;
  } ipm_core_req_t;

  typedef struct packed {
    logic [`IPM_NPRIO-1:0][15:0] prio;
    logic [`IPM_VBA_W-1:0] vector_table_base;
    logic [`IPM_VEC_W-1:0] fast_match_0;
    logic [15:0] fast_vector_low_0;
    logic [`IPM_FIVAH_W-1:0] fast_vector_high_0;
    logic [`IPM_VEC_W-1:0] fast_match_1;
    logic [15:0] fast_vector_low_1;
    logic [`IPM_FIVAH_W-1:0] fast_vector_high_1;
    logic global_disable;
    logic edge_a;
    logic edge_b;
    logic latch_a;
    logic latch_b;
    logic pin_a_prev;
    logic pin_b_prev;
    logic [1:0] current_priority_field;
    ipm_core_req_t core;
    logic [15:0] rdata;
    logic rvalid;
  } ipm_state_t;

endpackage : ipm_pkg

// >>> core/ipm_lowest_finder.sv
// Finds the lowest-numbered active request in one priority level.
// Purely combinational; the caller registers whatever it uses.
`timescale 1ns/1ns
`include "ipm_consts.svh"

module ipm_lowest_finder
  import ipm_pkg::*;
(
  input wire logic [`IPM_NSRC-1:0] req,
  output logic found,
  output logic [`IPM_VEC_W-1:0] index
);

  always_comb
  begin
    found = 1'b0;
    index = '0;
    // Scanning downwards lets the lowest source number overwrite the rest.
    for (int s = `IPM_NSRC - 1; s >= 0; s--)
    begin
      if (req[s])
      begin
        found = 1'b1;
        index = s[`IPM_VEC_W-1:0];
      end
    end
  end

endmodule : ipm_lowest_finder

// >>> core/ipm_interrupt_arbiter.sv
// Priority interrupt controller: register map, request arbitration and
// vector generation. Registers sit on a word-addressed peripheral bus with
// a one-cycle registered read; all inputs are synchronous to core_clk.
//
// Contract
// (R1) Decode base plus offset, answer mapped offsets only.
// (R2) Twenty-four 16-bit registers; gap offsets reserved.
// (R3) Ten priority registers of 2-bit level fields.
// (R4) First register: breakpoint 13:12, step counter 11:10.
// (R5) Third register fields, bits 5:4 read zero.
// (R6) Vector base register, top three bits zero.
// (R7) Fast match registers, bits 15:7 zero.
// (R8) Fast vector address low full, high partial.
// (R9) Six pending registers; last pads with ones.
// (R10) Control register: state, level, vector, disable, pins.
// (R11) Lowest source number wins within a level.
// (R12) Level-2 fast match outputs fast vector address.
// (R13) In low power, external pins low-level sensitive.
`timescale 1ns/1ns
`include "ipm_consts.svh"

module ipm_interrupt_arbiter
  import ipm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire ipm_pkg::ipm_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic [`IPM_NSRC-1:0] irq_src,
  input wire logic external_request_a_n,
  input wire logic external_request_b_n,
  input wire logic low_power,
  input wire logic [1:0] core_mask,
  input wire logic core_ack,
  output ipm_pkg::ipm_core_req_t core_req
);

  import ipm_pkg::*;

  ipm_state_t st_r;
  ipm_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  logic sel;
  logic [`IPM_OFF_W-1:0] off;
  logic mapped;

  // Only the bits above the offset field pick this block out of the bus.
  localparam logic [23:0] BASE_ADDR = `IPM_BASE_ADDR;

  assign off = bus_req.addr[`IPM_OFF_W-1:0];
  assign sel = (bus_req.addr[23:`IPM_OFF_W] == BASE_ADDR[23:`IPM_OFF_W]); // R1
  assign mapped = sel && (off <= `IPM_OFF_PEND_5 || off == `IPM_OFF_CTRL); // R2

  ////////////////////////////////////////////////////////////////////////////
  // Per-source level decode and effective requests.

  logic [`IPM_NSRC-1:0] eff_req;
  logic [`IPM_NSRC-1:0][1:0] src_lvl;
  logic ext_a_req;
  logic ext_b_req;

  // External pins: low level, or a latched falling edge when edge mode is set outside low power.
  assign ext_a_req = (low_power || !st_r.edge_a) ? !external_request_a_n : st_r.latch_a; // R13
  assign ext_b_req = (low_power || !st_r.edge_b) ? !external_request_b_n : st_r.latch_b; // R13

  genvar gs;
  generate
    for (gs = 0; gs < `IPM_NSRC; gs++)
    begin : g_src
      logic raw;
      logic [1:0] code;
      if (gs < `IPM_FIXED_SRC)
      begin : g_fixed
        assign code = 2'h3;
        assign src_lvl[gs] = 2'h3;
      end
      else
      begin : g_prog
        localparam int F = gs - `IPM_FIXED_SRC;
        assign code = st_r.prio[F / 8][2 * (F % 8) +: 2]; // R3
        // First two registers encode levels 1..3, the rest levels 0..2.
        assign src_lvl[gs] = (F < 16) ? code : code - 2'h1;
      end
      if (gs == `IPM_SRC_EXT_A)
      begin : g_ea
        assign raw = ext_a_req;
      end
      else if (gs == `IPM_SRC_EXT_B)
      begin : g_eb
        assign raw = ext_b_req;
      end
      else
      begin : g_pl
        assign raw = irq_src[gs];
      end
      assign eff_req[gs] = raw && (code != 2'h0);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // One lowest-number search per priority level.

  logic [3:0] lvl_found;
  logic [3:0][`IPM_VEC_W-1:0] lvl_index;

  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++)
    begin : g_lvl
      logic [`IPM_NSRC-1:0] lvl_req;
      always_comb
      begin
        for (int s = 0; s < `IPM_NSRC; s++)
        begin
          lvl_req[s] = eff_req[s] && (src_lvl[s] == 2'(gl));
        end
      end
      ipm_lowest_finder u_find (
        .req(lvl_req),
        .found(lvl_found[gl]),
        .index(lvl_index[gl])
      ); // R11
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Winner selection and vector address.

  logic win;
  logic [1:0] win_lvl;
  logic [`IPM_VEC_W-1:0] win_vec;
  logic [`IPM_VAB_W-1:0] win_vab;

  always_comb
  begin
    win = 1'b0;
    win_lvl = 2'h0;
    win_vec = '0;
    // Ascending scan so the highest permitted level is left standing.
    for (int l = 0; l < 4; l++)
    begin
      if (lvl_found[l] && (l[1:0] >= core_mask) && !st_r.global_disable)
      begin
        win = 1'b1;
        win_lvl = l[1:0];
        win_vec = lvl_index[l];
      end
    end
    // Set 0 is checked first, so it wins when both match registers agree.
    if (win_lvl == 2'h2 && win_vec == st_r.fast_match_0)
    begin
      win_vab = {st_r.fast_vector_high_0, st_r.fast_vector_low_0}; // R12
    end
    else if (win_lvl == 2'h2 && win_vec == st_r.fast_match_1)
    begin
      win_vab = {st_r.fast_vector_high_1, st_r.fast_vector_low_1}; // R12
    end
    else
    begin
      win_vab = {st_r.vector_table_base, win_vec, 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  logic [15:0] rd_word;
  logic [15:0] ctrl_word;
  logic [95:0] pend_all;

  // Pending bit p reports source p + 1, so the last source lands on bit 0 of
  // the last register; the bits above it read as one.
  localparam logic [15:0] PEND5_FILL = `IPM_PEND5_FILL;

  genvar gp;
  generate
    for (gp = 0; gp < 96; gp++)
    begin : g_pend
      if (gp + 1 < `IPM_NSRC)
      begin : g_flag
        assign pend_all[gp] = eff_req[gp + 1]; // R9
      end
      else
      begin : g_fill
        assign pend_all[gp] = PEND5_FILL[gp - 80];
      end
    end
  endgenerate

  always_comb
  begin
    ctrl_word = `IPM_RST_WORD;
    ctrl_word[`IPM_CTRL_INT] = st_r.core.req; // R10
    ctrl_word[`IPM_CTRL_CURRENT_PRIORITY_FIELD_LO +: 2] = st_r.current_priority_field;
    ctrl_word[`IPM_CTRL_VAB_LO +: `IPM_VEC_W] = st_r.core.vector;
    ctrl_word[`IPM_CTRL_DIS] = st_r.global_disable;
    ctrl_word[`IPM_CTRL_ONE] = 1'b1;
    ctrl_word[`IPM_CTRL_STB] = external_request_b_n;
    ctrl_word[`IPM_CTRL_STA] = external_request_a_n;
    ctrl_word[`IPM_CTRL_EDB] = st_r.edge_b;
    ctrl_word[`IPM_CTRL_EDA] = st_r.edge_a;
  end

  always_comb
  begin
    rd_word = `IPM_RST_WORD;
    if (off <= `IPM_OFF_PRIO_9)
    begin
      rd_word = st_r.prio[off[3:0]];
    end
    else if (off >= `IPM_OFF_PEND_0 && off <= `IPM_OFF_PEND_5)
    begin
      rd_word = pend_all[16 * (off - `IPM_OFF_PEND_0) +: 16]; // R9
    end
    else
    begin
      unique case (off)
        `IPM_OFF_VBA: rd_word = {3'h0, st_r.vector_table_base}; // R6
        `IPM_OFF_FAST_MATCH_0: rd_word = {9'h000, st_r.fast_match_0}; // R7
        `IPM_OFF_FAST_VECTOR_LOW_0: rd_word = st_r.fast_vector_low_0; // R8
        `IPM_OFF_FAST_VECTOR_HIGH_0: rd_word = {11'h000, st_r.fast_vector_high_0}; // R8
        `IPM_OFF_FAST_MATCH_1: rd_word = {9'h000, st_r.fast_match_1}; // R7
        `IPM_OFF_FAST_VECTOR_LOW_1: rd_word = st_r.fast_vector_low_1; // R8
        `IPM_OFF_FAST_VECTOR_HIGH_1: rd_word = {11'h000, st_r.fast_vector_high_1}; // R8
        `IPM_OFF_CTRL: rd_word = ctrl_word; // R10
        default: rd_word = `IPM_RST_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Writable bits of each priority register; the rest read as zero.
  function automatic logic [15:0] prio_mask(input logic [3:0] idx);
    unique case (idx)
      4'h0: prio_mask = `IPM_PRIO0_MASK; // R4
      4'h1: prio_mask = `IPM_PRIO1_MASK;
      4'h2: prio_mask = `IPM_PRIO2_MASK; // R5
      default: prio_mask = `IPM_PRIO_MASK;
    endcase
  endfunction : prio_mask

  logic do_wr;
  logic [15:0] wd;

  assign do_wr = bus_req.wr && mapped;
  assign wd = bus_req.wdata;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pin_a_prev = external_request_a_n;
    st_nxt.pin_b_prev = external_request_b_n;
    // An acknowledge of an external source clears its edge latch.
    if (core_ack && st_r.core.req && st_r.core.vector == `IPM_SRC_EXT_A)
    begin
      st_nxt.latch_a = 1'b0;
    end
    if (core_ack && st_r.core.req && st_r.core.vector == `IPM_SRC_EXT_B)
    begin
      st_nxt.latch_b = 1'b0;
    end
    // Edges are latched in edge mode only; a new edge wins over an acknowledge clear.
    if (st_r.edge_a && st_r.pin_a_prev && !external_request_a_n)
    begin
      st_nxt.latch_a = 1'b1;
    end
    if (st_r.edge_b && st_r.pin_b_prev && !external_request_b_n)
    begin
      st_nxt.latch_b = 1'b1;
    end
    if (core_ack && st_r.core.req)
    begin
      unique case (st_r.core.level)
        2'h0: st_nxt.current_priority_field = 2'h1;
        2'h1: st_nxt.current_priority_field = 2'h2;
        default: st_nxt.current_priority_field = 2'h3;
      endcase
    end
    if (do_wr)
    begin
      if (off <= `IPM_OFF_PRIO_9)
      begin
        st_nxt.prio[off[3:0]] = wd & prio_mask(off[3:0]); // R3
      end
      unique case (off)
        `IPM_OFF_VBA: st_nxt.vector_table_base = wd[`IPM_VBA_W-1:0]; // R6
        `IPM_OFF_FAST_MATCH_0: st_nxt.fast_match_0 = wd[`IPM_VEC_W-1:0]; // R7
        `IPM_OFF_FAST_VECTOR_LOW_0: st_nxt.fast_vector_low_0 = wd; // R8
        `IPM_OFF_FAST_VECTOR_HIGH_0: st_nxt.fast_vector_high_0 = wd[`IPM_FIVAH_W-1:0]; // R8
        `IPM_OFF_FAST_MATCH_1: st_nxt.fast_match_1 = wd[`IPM_VEC_W-1:0]; // R7
        `IPM_OFF_FAST_VECTOR_LOW_1: st_nxt.fast_vector_low_1 = wd; // R8
        `IPM_OFF_FAST_VECTOR_HIGH_1: st_nxt.fast_vector_high_1 = wd[`IPM_FIVAH_W-1:0]; // R8
        `IPM_OFF_CTRL:
        begin
          st_nxt.global_disable = wd[`IPM_CTRL_DIS]; // R10
          st_nxt.edge_b = wd[`IPM_CTRL_EDB];
          st_nxt.edge_a = wd[`IPM_CTRL_EDA];
          // A latch left over from edge mode must not fire after a later switch.
          if (!wd[`IPM_CTRL_EDA])
          begin
            st_nxt.latch_a = 1'b0;
          end
          if (!wd[`IPM_CTRL_EDB])
          begin
            st_nxt.latch_b = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
    st_nxt.core.req = win;
    st_nxt.core.level = win_lvl;
    st_nxt.core.vector = win_vec;
    st_nxt.core.vector_address_bus = win_vab;
    st_nxt.rvalid = bus_req.rd && mapped; // R1
    st_nxt.rdata = (bus_req.rd && mapped) ? rd_word : `IPM_RST_WORD;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      st_r <= '0;
      st_r.pin_a_prev <= 1'b1;
      st_r.pin_b_prev <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign bus_rdata = st_r.rdata;
  assign bus_rvalid = st_r.rvalid;
  assign core_req = st_r.core;

endmodule : ipm_interrupt_arbiter

// >>> tb/ipm_arbiter_asserts.sv
// Checker for the interrupt arbiter register bus answers.
// Assumes ipm_pkg is compiled first and binds to ipm_interrupt_arbiter.
`timescale 1ns/1ns

module ipm_arbiter_asserts
  import ipm_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire ipm_pkg::ipm_bus_req_t bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_rvalid
);
  logic mapped;
  logic [4:0] off_q;
  assign mapped = (bus_req.addr[23:5] == 19'h0078D)
    && (bus_req.addr[4:0] <= 5'h16 || bus_req.addr[4:0] == 5'h1D);
  // Remembers which offset the current answer belongs to.
  always_ff @(posedge core_clk)
  begin
    off_q <= bus_req.addr[4:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_mapped_read;
    bus_req.rd && mapped;
  endsequence
  sequence s_answer(logic [4:0] o);
    bus_rvalid && off_q == o;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_read_answer: assert property (s_mapped_read |=> bus_rvalid)
    else $error("Mapped read got no answer.");
  a_answer_cause: assert property (bus_rvalid |-> $past(bus_req.rd && mapped))
    else $error("Answer without a mapped read.");
  a_foreign_silent: assert property (bus_req.rd && !mapped |=> !bus_rvalid && bus_rdata == 16'h0000)
    else $error("Unmapped read was answered.");
  a_prio1_bits: assert property (s_answer(5'h01) |-> bus_rdata[15:6] == 10'h000)
    else $error("Priority register 1 upper bits set.");
  a_prio0_bits: assert property (s_answer(5'h00) |-> (bus_rdata & 16'hC3FF) == 16'h0000)
    else $error("Priority register 0 spare bits set.");
  a_prio2_gap: assert property (s_answer(5'h02) |-> bus_rdata[5:4] == 2'b00)
    else $error("Priority register 2 gap bits set.");
  a_vba_top: assert property (s_answer(5'h0A) |-> bus_rdata[15:13] == 3'b000)
    else $error("Vector base top bits set.");
  a_match_top: assert property (s_answer(5'h0B) or s_answer(5'h0E) |-> bus_rdata[15:7] == 9'h000)
    else $error("Fast match upper bits set.");
  a_high_top: assert property (s_answer(5'h0D) or s_answer(5'h10) |-> bus_rdata[15:5] == 11'h000)
    else $error("Fast vector high upper bits set.");
  a_pend_fill: assert property (s_answer(5'h16) |-> bus_rdata[15:1] == 15'h7FFF)
    else $error("Last pending register padding wrong.");
  a_ctrl_one: assert property (s_answer(5'h1D) |-> bus_rdata[4])
    else $error("Control bit 4 not one.");
endmodule : ipm_arbiter_asserts

bind ipm_interrupt_arbiter ipm_arbiter_asserts ipm_arbiter_asserts_inst (
  .core_clk(core_clk),
  .srst(srst),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .bus_rvalid(bus_rvalid)
);

// >>> tb/ipm_core_model.sv
// Processor core model: takes presented interrupts after a set delay.
// Assumes ipm_pkg is compiled first; the bench gates acknowledges.
`timescale 1ns/1ns

module ipm_core_model
  import ipm_pkg::*;
#(
  parameter int ACK_DELAY = 3
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ack_en,
  input wire logic [1:0] mask_set,
  input wire ipm_pkg::ipm_core_req_t core_req,
  output logic core_ack,
  output logic [1:0] core_mask
);
  logic [3:0] wait_r;
  assign core_mask = mask_set;
  // The acknowledge is a one-cycle pulse taken only while a request stands.
  always_ff @(posedge core_clk)
  begin
    if (srst || !core_req.req || !ack_en)
    begin
      wait_r <= 4'h0;
      core_ack <= 1'b0;
    end
    else
    begin
      core_ack <= (wait_r == 4'(ACK_DELAY));
      wait_r <= (wait_r == 4'(ACK_DELAY)) ? 4'h0 : wait_r + 4'h1;
    end
  end
endmodule : ipm_core_model

// >>> tb/interrupt_priority_register_map_tb.sv
// Self-checking bench for the interrupt arbiter and its register map.
// Assumes the core files, the checker and the core model are compiled first.
`timescale 1ns/1ns
`include "ipm_consts.svh"

module interrupt_priority_register_map_tb;
  import ipm_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  ipm_bus_req_t bus_req = '0;
  logic [15:0] bus_rdata;
  logic bus_rvalid;
  logic [`IPM_NSRC-1:0] irq_src = '0;
  logic pin_a_n = 1'b1;
  logic pin_b_n = 1'b1;
  logic [1:0] mask_set = 2'h0;
  logic low_power = 1'b0;
  logic ack_en = 1'b0;
  logic [1:0] core_mask;
  logic core_ack;
  ipm_core_req_t core_req;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  ipm_interrupt_arbiter ipm_interrupt_arbiter_inst (.core_clk(core_clk), .srst(srst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .irq_src(irq_src),
    .external_request_a_n(pin_a_n), .external_request_b_n(pin_b_n), .low_power(low_power),
    .core_mask(core_mask), .core_ack(core_ack), .core_req(core_req));
  ipm_core_model #(.ACK_DELAY(3)) ipm_core_model_inst (.core_clk(core_clk), .srst(srst),
    .ack_en(ack_en), .mask_set(mask_set), .core_req(core_req), .core_ack(core_ack),
    .core_mask(core_mask));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic bus_read(input logic [23:0] a, output logic [15:0] d, output logic v);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
    d = bus_rdata;
    v = bus_rvalid;
  endtask : bus_read
  task automatic bus_write(input logic [23:0] a, input logic [15:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus_req <= '0;
    @(posedge core_clk);
  endtask : bus_write
  task automatic rd_chk(input logic [4:0] o, input logic [15:0] e);
    logic [15:0] d;
    logic v;
    bus_read(`IPM_BASE_ADDR | 24'(o), d, v);
    chk("rvalid", 24'h1, 24'(v));
    chk($sformatf("reg %h", o), 24'(e), 24'(d));
  endtask : rd_chk
  task automatic wait_req(input logic lvl);
    for (int i = 0; i < 50 && core_req.req !== lvl; i++) @(posedge core_clk);
    chk("req", 24'(lvl), 24'(core_req.req));
  endtask : wait_req
  function automatic logic [15:0] full_mask(input logic [4:0] o);
    case (o)
      5'h00: return 16'h3C00;
      5'h01: return 16'h003F;
      5'h02: return 16'hFFCF;
      5'h0A: return 16'h1FFF;
      5'h0B, 5'h0E: return 16'h007F;
      5'h0D, 5'h10: return 16'h001F;
      5'h16: return 16'hFFFE;
      default: return (o > 5'h10) ? 16'h0000 : 16'hFFFF;
    endcase
  endfunction : full_mask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    for (int o = 0; o <= 16'h16; o++) rd_chk(5'(o), (o == 16'h16) ? 16'hFFFE : 16'h0000);
    rd_chk(5'h1D, 16'h001C);
  endtask : t_reset_values
  task automatic t_write_masks;
    logic [15:0] d;
    logic v;
    for (int o = 0; o <= 16'h16; o++) bus_write(`IPM_BASE_ADDR | 24'(o), 16'hFFFF);
    for (int o = 0; o <= 16'h16; o++) rd_chk(5'(o), full_mask(5'(o)));
    bus_read(`IPM_BASE_ADDR | 24'h17, d, v);
    chk("gap read", 24'h0, {7'h0, v, d});
    bus_read(24'h00F1C0, d, v);
    chk("foreign read", 24'h0, {7'h0, v, d});
    bus_write(24'h00F1C0, 16'h0000);
    rd_chk(5'h00, 16'h3C00);
  endtask : t_write_masks
  task automatic t_arbitrate;
    irq_src[40] <= 1'b1;
    irq_src[30] <= 1'b1;
    wait_req(1'b1);
    chk("vector", 24'd30, 24'(core_req.vector));
    chk("level", 24'h2, 24'(core_req.level));
    chk("vab", {3'h0, 13'h1FFF, 7'd30, 1'b0}, 24'(core_req.vector_address_bus));
    rd_chk(5'h12, 16'h2000);
    rd_chk(5'h13, 16'h0080);
    bus_write(`IPM_BASE_ADDR | 24'h0B, 16'h001E);
    bus_write(`IPM_BASE_ADDR | 24'h0C, 16'h1234);
    bus_write(`IPM_BASE_ADDR | 24'h0D, 16'h0005);
    repeat (2) @(posedge core_clk);
    chk("fast vab", 24'h051234, 24'(core_req.vector_address_bus));
    mask_set <= 2'h3;
    wait_req(1'b0);
    mask_set <= 2'h2;
    wait_req(1'b1);
    bus_write(`IPM_BASE_ADDR | 24'h1D, 16'h0020);
    wait_req(1'b0);
    bus_write(`IPM_BASE_ADDR | 24'h1D, 16'h0000);
    wait_req(1'b1);
    mask_set <= 2'h0;
    irq_src <= '0;
    wait_req(1'b0);
  endtask : t_arbitrate
  task automatic t_pins;
    bus_write(`IPM_BASE_ADDR | 24'h1D, 16'h0001);
    pin_a_n <= 1'b0;
    wait_req(1'b1);
    chk("pin vector", 24'h12, 24'(core_req.vector));
    ack_en <= 1'b1;
    wait_req(1'b0);
    ack_en <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("held pin", 24'h0, 24'(core_req.req));
    low_power <= 1'b1;
    wait_req(1'b1);
    chk("sleep vector", 24'h12, 24'(core_req.vector));
    rd_chk(5'h1D, 16'hE499);
    pin_b_n <= 1'b0;
    rd_chk(5'h1D, 16'hE491);
    rd_chk(5'h12, 16'h0006);
    pin_a_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("pin b vector", 24'h13, 24'(core_req.vector));
    low_power <= 1'b0;
    pin_b_n <= 1'b1;
  endtask : t_pins
  task end_of_test;
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset_values();
    t_write_masks();
    t_arbitrate();
    t_pins();
    end_of_test();
  end
endmodule : interrupt_priority_register_map_tb
